// *** adcrd_regs.svh ***
`ifndef ADCRD_REGS_SVH
`define ADCRD_REGS_SVH

// ------------------------------------------------------------
// Timing figures in ns and derived cycle counts
// ------------------------------------------------------------
`define ADCRD_CLK_NS        10
`define ADCRD_BUSY_PGA_NS   100
`define ADCRD_BUSY_BYP_NS   30
`define ADCRD_CONV_PGA_NS   1550
`define ADCRD_CONV_BYP_NS   660
`define ADCRD_BUSY_PGA_CYC  (`ADCRD_BUSY_PGA_NS / `ADCRD_CLK_NS)
`define ADCRD_BUSY_BYP_CYC  (`ADCRD_BUSY_BYP_NS / `ADCRD_CLK_NS)
`define ADCRD_CONV_PGA_CYC  (`ADCRD_CONV_PGA_NS / `ADCRD_CLK_NS)
`define ADCRD_CONV_BYP_CYC  (`ADCRD_CONV_BYP_NS / `ADCRD_CLK_NS)

// ------------------------------------------------------------
// Serial word layout
// ------------------------------------------------------------
`define ADCRD_DATA_BITS     14
`define ADCRD_EXTRA_BITS    6
`define ADCRD_WORD_BITS     20
`define ADCRD_WORD_MSB      19
`define ADCRD_CHAN_POS      14
`define ADCRD_GAIN_POS      17
`define ADCRD_FIFO_DEPTH    4
`define ADCRD_CNT_W         8

`endif

// *** adcrd_pkg.sv ***
package adcrd_pkg;
  `include "adcrd_regs.svh"

  typedef struct packed {
    logic [2:0] chan;
    logic [2:0] gain;
  } adcrd_sel_t;

  typedef struct packed {
    logic [`ADCRD_DATA_BITS-1:0] data;
    adcrd_sel_t                  sel;
  } adcrd_word_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_READ
  } adcrd_state_t;
endpackage

// *** adcrd_top.sv ***
`timescale 1ns/1ns
`include "adcrd_regs.svh"
// Summary of operation
// RULE_01: Host holds select high 150ns, normal.
// RULE_02: Busy rises within 100ns, 30ns bypassed.
// RULE_03: Conversion ends within 1550ns or 660ns.
// RULE_04: Host gives 14 clock rises per result.
// RULE_05: Last clock may be half period.
// RULE_06: Host clock at most 50MHz.
// RULE_07: Six more clocks read appended bits.
// RULE_08: Channel bits then gain bits, MSB first.
// RULE_09: Host sample period covers all phases.
// RULE_10: Low power: select high time is acquisition.
// RULE_11: Host holds select high 500ns, low power.
// RULE_12: Low power: use minimum 500ns high width.
// RULE_13: Low power first conversion is valid.
// RULE_14: Data pin released high, driven low.
// RULE_15: Busy over conversion, then MSB, shifts.
// RULE_16: Host keeps clock low while busy.
// RULE_17: Fewer extra clocks give fewer extra bits.
// RULE_18: Host waits busy low before clocking.

// ------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------
module adcrd_fifo #(
  parameter int W = 14,
  parameter int D = 4
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          ready_r;

  wire push_w = in_valid_i && ready_r;
  wire pop_w  = out_ready_i && (cnt_r != '0);
  always_comb begin
    cnt_nxt = cnt_r;
    if (push_w && !pop_w) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop_w && !push_w) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end
  function automatic logic [AW-1:0] adv(input logic [AW-1:0] p);
    adv = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction
  // Ready is a flop of its own so the top output comes from a register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_r    <= '0;
      rd_r    <= '0;
      cnt_r   <= '0;
      ready_r <= 1'b1;
    end else begin
      if (push_w) wr_r <= adv(wr_r);
      if (pop_w)  rd_r <= adv(rd_r);
      cnt_r   <= cnt_nxt;
      ready_r <= (cnt_nxt != CW'(D));
    end
  end
  always_ff @(posedge clk_i) begin
    if (push_w) mem_r[wr_r] <= in_data_i;
  end

  assign in_ready_o  = ready_r;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_r];
endmodule // adcrd_fifo

// ------------------------------------------------------------
// Conversion and serial readout
// ------------------------------------------------------------
module adcrd_top
  import adcrd_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        sck_i,
  input  wire logic                        low_power_select_pin_i,
  input  wire logic                        gain_bypass_i,
  input  wire logic [2:0]                  chan_sel_i,
  input  wire logic [2:0]                  gain_sel_i,
  input  wire logic                        sample_valid_i,
  input  wire logic [`ADCRD_DATA_BITS-1:0] sample_data_i,
  output logic                             sample_ready_o,
  output logic                             busy_o,
  output logic                             sdo_o,
  output logic                             sdo_oe_o,
  output logic                             result_valid_o,
  output logic                             underrun_o
);
  localparam int CONV_PGA = `ADCRD_CONV_PGA_CYC;
  localparam int CONV_BYP = `ADCRD_CONV_BYP_CYC;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [10:0] pin_s1_r;
  logic [10:0] pin_s2_r;
  logic        cs_prev_r;
  logic        sck_prev_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_s1_r   <= 11'h7FF;
      pin_s2_r   <= 11'h7FF;
      cs_prev_r  <= 1'b1;
      sck_prev_r <= 1'b1;
    end else begin
      pin_s1_r   <= {cs_n_i, sck_i, low_power_select_pin_i, gain_bypass_i,
                     chan_sel_i, gain_sel_i, 1'b0};
      pin_s2_r   <= pin_s1_r;
      cs_prev_r  <= pin_s2_r[10];
      sck_prev_r <= pin_s2_r[9];
    end
  end

  wire        cs_s_w    = pin_s2_r[10];
  wire        sck_s_w   = pin_s2_r[9];
  wire        lp_s_w    = pin_s2_r[8];
  wire        byp_s_w   = pin_s2_r[7];
  adcrd_sel_t sel_s_w;
  assign sel_s_w   = adcrd_sel_t'(pin_s2_r[6:1]);
  wire cs_fall_w   = cs_prev_r && !cs_s_w;
  wire cs_rise_w   = !cs_prev_r && cs_s_w;
  wire sck_rise_w  = !sck_prev_r && sck_s_w;

  // ----------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------
  logic                        head_valid_w;
  logic [`ADCRD_DATA_BITS-1:0] head_data_w;
  logic                        pop_w;

  adcrd_fifo #(
    .W (`ADCRD_DATA_BITS),
    .D (`ADCRD_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (sample_valid_i),
    .in_data_i   (sample_data_i),
    .in_ready_o  (sample_ready_o),
    .out_valid_o (head_valid_w),
    .out_ready_i (pop_w),
    .out_data_o  (head_data_w)
  );

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  adcrd_state_t                st_r;
  logic [`ADCRD_CNT_W-1:0]     conv_cnt_r;
  logic [`ADCRD_WORD_MSB:0]    shift_r;
  logic [4:0]                  bit_r;
  adcrd_sel_t                  sel_latch_r;
  adcrd_sel_t                  conv_sel_r;
  logic                        busy_r;
  logic                        oe_r;
  logic                        warm_r;
  logic                        valid_r;
  logic                        under_r;

  wire start_w    = cs_fall_w && (st_r == ST_IDLE);
  wire conv_end_w = (st_r == ST_CONV) && (conv_cnt_r == '0) && !cs_rise_w;
  assign pop_w    = conv_end_w && head_valid_w;

  wire [`ADCRD_CNT_W-1:0] conv_len_w = byp_s_w ?       // RULE_03
      `ADCRD_CNT_W'(CONV_BYP - 1) : `ADCRD_CNT_W'(CONV_PGA - 1);
  wire [`ADCRD_DATA_BITS-1:0] res_w = head_valid_w ? head_data_w : '0;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r        <= ST_IDLE;
      conv_cnt_r  <= '0;
      shift_r     <= '0;
      bit_r       <= '0;
      sel_latch_r <= '0;
      conv_sel_r  <= '0;
      busy_r      <= 1'b0;
      oe_r        <= 1'b0;
      warm_r      <= 1'b0;
      valid_r     <= 1'b0;
      under_r     <= 1'b0;
    end else if (cs_rise_w) begin
      st_r        <= ST_IDLE;
      busy_r      <= 1'b0;
      oe_r        <= 1'b0;                               // RULE_14
      sel_latch_r <= sel_s_w;
      warm_r      <= 1'b1;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (cs_fall_w) begin                           // RULE_10
            st_r       <= ST_CONV;
            busy_r     <= 1'b1;                          // RULE_02
            oe_r       <= 1'b1;                          // RULE_14
            shift_r    <= '0;
            conv_cnt_r <= conv_len_w;
            conv_sel_r <= sel_latch_r;
            valid_r    <= lp_s_w || warm_r;              // RULE_13
          end
        end
        ST_CONV: begin
          if (conv_cnt_r == '0) begin
            st_r    <= ST_READ;
            busy_r  <= 1'b0;                             // RULE_15
            shift_r <= {res_w, conv_sel_r};              // RULE_08 RULE_07
            bit_r   <= '0;
            under_r <= !head_valid_w;
          end else begin
            conv_cnt_r <= conv_cnt_r - `ADCRD_CNT_W'(1);
          end
        end
        ST_READ: begin
          if (sck_rise_w) begin                          // RULE_15
            shift_r <= {shift_r[`ADCRD_WORD_MSB-1:0], 1'b0}; // RULE_17
            if (bit_r != 5'(`ADCRD_WORD_BITS)) bit_r <= bit_r + 5'h01;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign busy_o         = busy_r;
  assign sdo_o          = shift_r[`ADCRD_WORD_MSB];
  assign sdo_oe_o       = oe_r;
  assign result_valid_o = valid_r;
  assign underrun_o     = under_r;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  localparam int BUSY_MAX = `ADCRD_BUSY_BYP_CYC;
  logic [`ADCRD_CNT_W-1:0] busy_len_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !busy_r) busy_len_r <= '0;
    else busy_len_r <= busy_len_r + `ADCRD_CNT_W'(1);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  busy_rise_a: assert property (start_w |=> busy_r && oe_r) // RULE_02
    else $error("busy not raised after select fall");
  busy_delay_a: assert property ($fell(cs_n_i) && st_r == ST_IDLE // RULE_02
      ##1 !cs_n_i [*2] |-> ##[1:BUSY_MAX] busy_r)
    else $error("busy rise too late");
  // Busy length counter already holds the full count when busy has fallen
  conv_pga_a: assert property ($fell(busy_r) && !$past(byp_s_w) // RULE_03
      && !$past(cs_rise_w) |-> busy_len_r <= CONV_PGA)
    else $error("conversion too long with gain stage");
  conv_byp_a: assert property ($fell(busy_r) && $past(byp_s_w) // RULE_03
      && !$past(cs_rise_w) |-> busy_len_r == CONV_BYP)
    else $error("bypassed conversion length wrong");
  sdo_release_a: assert property (cs_rise_w |=> !sdo_oe_o) // RULE_14
    else $error("data pin driven while select high");
  sdo_low_a: assert property (start_w |=> sdo_oe_o && !sdo_o) // RULE_14
    else $error("data pin not low at conversion start");
  msb_out_a: assert property (conv_end_w |=> !busy_o // RULE_15
      && sdo_o == $past(res_w[`ADCRD_DATA_BITS-1]))
    else $error("top bit missing at busy fall");
  shift_a: assert property (st_r == ST_READ && sck_rise_w // RULE_15
      && !cs_rise_w |=> sdo_o == $past(shift_r[`ADCRD_WORD_MSB-1]))
    else $error("readout did not shift");
  chan_bit_a: assert property (st_r == ST_READ // RULE_08
      && bit_r == 5'(`ADCRD_CHAN_POS) |-> sdo_o == conv_sel_r.chan[2])
    else $error("channel bit out of order");
  gain_bit_a: assert property (st_r == ST_READ // RULE_08
      && bit_r == 5'(`ADCRD_GAIN_POS) |-> sdo_o == conv_sel_r.gain[2])
    else $error("gain bit out of order");
  tail_a: assert property (st_r == ST_READ // RULE_17 RULE_07
      && bit_r == 5'(`ADCRD_WORD_BITS) |-> !sdo_o)
    else $error("extra bits past appended field");
  lp_valid_a: assert property (start_w && lp_s_w |=> result_valid_o) // RULE_13
    else $error("low power conversion marked invalid");

  full_read_c: cover property (st_r == ST_READ
      && bit_r == 5'(`ADCRD_WORD_BITS));
  byp_conv_c: cover property ($fell(busy_r) && $past(byp_s_w));
  abort_c: cover property (st_r == ST_CONV && cs_rise_w);
  fifo_full_c: cover property (!sample_ready_o);
endmodule // adcrd_top

// *** adcrd_host.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host model: select, serial clock and data readout
// ------------------------------------------------------------
module adcrd_host (
  input  wire logic clk_i,
  input  wire logic busy_i,
  input  wire logic sdo_i,
  input  wire logic oe_i,
  output logic      cs_n_o,
  output logic      sck_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
  end

  // Serial clock stands low outside frames; 80ns period
  task automatic frame(input int hold, input int nbits, input bit abort,
                       output logic [19:0] w, output logic [1:0] pre,
                       output int dly, output int conv);
    w = 20'h00000;
    dly = 0;
    conv = 0;
    @(negedge clk_i);
    #3;
    #(hold);
    cs_n_o = 1'b0;
    while (busy_i !== 1'b1 && dly < 200) begin
      @(posedge clk_i);
      #1;
      dly++;
    end
    pre = {oe_i, sdo_i};
    if (abort) begin
      #200;
    end else begin
      while (busy_i !== 1'b0 && conv < 400) begin
        @(posedge clk_i);
        #1;
        conv++;
      end
      for (int i = 0; i < nbits; i++) begin
        #40;
        w[19-i] = sdo_i;
        sck_o = 1'b1;
        #40;
        sck_o = 1'b0;
      end
      // Frames of 14 or 20 clocks end select with the last clock's fall
      if (nbits != 14 && nbits != 20) #40;
    end
    cs_n_o = 1'b1;
  endtask
endmodule // adcrd_host

// *** adcrd_tb.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module testbench;
  import adcrd_pkg::*;
  logic        clk_i, sys_rst_i, cs_n, sck, lp, byp, valid, ready;
  logic        busy, sdo, oe, rvalid, under;
  logic [2:0]  chan, gain;
  logic [13:0] data;
  logic [13:0] q[$];
  adcrd_sel_t  last_sel;
  int          n_fail, compares;

  adcrd_top u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck),
    .low_power_select_pin_i(lp), .gain_bypass_i(byp),
    .chan_sel_i(chan), .gain_sel_i(gain), .sample_valid_i(valid),
    .sample_data_i(data), .sample_ready_o(ready), .busy_o(busy),
    .sdo_o(sdo), .sdo_oe_o(oe), .result_valid_o(rvalid),
    .underrun_o(under)
  );
  adcrd_host u_host (
    .clk_i(clk_i), .busy_i(busy), .sdo_i(sdo), .oe_i(oe),
    .cs_n_o(cs_n), .sck_o(sck)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [19:0] seen,
                       input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic push(input logic [13:0] d);
    @(negedge clk_i);
    valid = 1'b1;
    data = d;
    @(negedge clk_i);
    valid = 1'b0;
  endtask

  // One frame; expected word from queued sample and latched selects
  task automatic run(input int hold, input int n, input bit abort,
                     input bit sel_ok, input int dmax, input int cmax);
    logic [19:0] w, e, m;
    logic [1:0]  pre;
    int          dly, conv;
    bit          emp;
    emp = (q.size() == 0);
    e = {emp ? 14'h0000 : q[0], last_sel};
    m = 20'hFFFFF << (20 - n);
    if (!sel_ok) m = m & 20'hFFFC0;
    u_host.frame(hold, n, abort, w, pre, dly, conv);
    check("busy delay", dly <= dmax, 1'b1);
    check("pin at start", pre, 2'b10);
    repeat (5) @(negedge clk_i);
    check("pin released", oe, 1'b0);
    last_sel = {chan, gain};
    if (abort) begin
      check("busy abort", busy, 1'b0);
    end else begin
      check("conv time", conv <= cmax, 1'b1);
      check("word", w & m, e & m);
      check("underrun", under, emp);
      if (!emp) void'(q.pop_front());
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    close_out();
  end

  initial begin
    sys_rst_i = 1'b1;
    {lp, byp, valid, data, chan, gain, last_sel} = '0;
    n_fail = 0;
    compares = 0;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    check("busy reset", busy, 1'b0);
    check("oe reset", oe, 1'b0);
    check("ready reset", ready, 1'b1);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) check("fifo full", ready, 1'b0);
      push(14'h01A5 + 14'h00F3 * i);
      if (i < 4) q.push_back(14'h01A5 + 14'h00F3 * i);
    end
    $display("test reset and fill done");
    chan = 3'h5;
    gain = 3'h2;
    run(150, 20, 0, 0, 10, 1550 / 10);
    check("first invalid", rvalid, 1'b0);
    chan = 3'h3;
    gain = 3'h6;
    run(150, 20, 0, 1, 10, 1550 / 10);
    check("second valid", rvalid, 1'b1);
    run(150, 17, 0, 1, 10, 1550 / 10);
    $display("test normal gain frames done");
    byp = 1'b1;
    run(150, 20, 1, 1, 3, 660 / 10);
    run(150, 20, 0, 1, 3, 660 / 10);
    run(150, 20, 0, 1, 3, 660 / 10);
    $display("test abort bypass underrun done");
    sys_rst_i = 1'b1;
    lp = 1'b1;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    push(14'h2C3B);
    q.push_back(14'h2C3B);
    run(500, 20, 0, 0, 3, 660 / 10);
    check("low power valid", rvalid, 1'b1);
    $display("test low power first frame done");
    push(14'h1E4D);
    q.push_back(14'h1E4D);
    run(500, 14, 0, 1, 3, 660 / 10);
    $display("test half period end done");
    close_out();
  end
endmodule // testbench
